/* File: include/crb_pkg.sv */
// crb_pkg: constants, offsets and carrier types for the receive buffering block
// assumes an apb master with 32-bit data and an 8-bit byte address
package crb_pkg;
	localparam int unsigned CRB_ID_W = 29;
	localparam logic [28:0] CRB_STD_ID_MASK = 29'h1FFC0000;
	// rx_accept_mode encodings
	localparam logic [1:0] CRB_MODE_ANY = 2'h0;
	localparam logic [1:0] CRB_MODE_STD = 2'h1;
	localparam logic [1:0] CRB_MODE_EXT = 2'h2;
	localparam logic [1:0] CRB_MODE_ALL = 2'h3;
	// register byte offsets
	localparam logic [7:0] CRB_OFS_CTRL0 = 8'h00;
	localparam logic [7:0] CRB_OFS_CTRL1 = 8'h04;
	localparam logic [7:0] CRB_OFS_FULL = 8'h08;
	localparam logic [7:0] CRB_OFS_IE = 8'h0C;
	localparam logic [7:0] CRB_OFS_OVF = 8'h10;
	localparam logic [7:0] CRB_OFS_PINCFG = 8'h14;
	localparam logic [7:0] CRB_OFS_SOFCTL = 8'h18;
	localparam logic [7:0] CRB_OFS_SLOT0 = 8'h20;
	localparam logic [7:0] CRB_OFS_SLOT1 = 8'h30;
	// word offsets inside a slot window
	localparam logic [1:0] CRB_SW_ID = 2'h0;
	localparam logic [1:0] CRB_SW_DLC = 2'h1;
	localparam logic [1:0] CRB_SW_DLO = 2'h2;
	localparam logic [1:0] CRB_SW_DHI = 2'h3;
	// rx_slot_control field positions
	localparam int unsigned CRB_CTL_MODE_LSB = 5;
	localparam int unsigned CRB_CTL_RTR_BIT = 3;
	localparam int unsigned CRB_CTL_ROLL_BIT = 2;
	localparam int unsigned CRB_CTL_ROLLCPY_BIT = 1;
	// full_pin_config field positions (bit per slot added)
	localparam int unsigned CRB_PIN_LVL_LSB = 4;
	localparam int unsigned CRB_PIN_EN_LSB = 2;
	localparam int unsigned CRB_PIN_MODE_LSB = 0;
	// values after reset
	localparam logic [1:0] CRB_RST_MODE = 2'h0;
	localparam logic [5:0] CRB_RST_PINCFG = 6'h00;
	localparam logic CRB_RST_SOF_EN = 1'b0;
	// sof detector timing: bit time and sample point in clk cycles, idle stretch in bit times
	localparam int unsigned CRB_BIT_CYC = 10;
	localparam int unsigned CRB_SAMPLE_CYC = 7;
	localparam int unsigned CRB_IDLE_BITS = 11;

	typedef struct packed {
		logic ide;
		logic rtr;
		logic [28:0] id;
		logic [3:0] dlc;
		logic [63:0] data;
	} crb_frame_t;

	typedef struct packed {
		logic ext;
		logic [28:0] id;
	} crb_filt_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} crb_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} crb_apb_rsp_t;
endpackage

/* File: tb/crb_can_node.sv */
// crb_can_node: far side model, frame hand-off from the protocol engine and the bus line
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
module crb_can_node (
	input wire logic clk,
	output crb_pkg::crb_frame_t pe_frame = '0,
	output logic pe_load = 1'b0,
	output logic pe_end = 1'b0,
	output logic pe_ok = 1'b0,
	output logic bus_receive_input = 1'b1
);
	import crb_pkg::*;
	task automatic send(input crb_frame_t f, input logic ok);
		pe_frame <= f;
		pe_load <= 1'b1;
		@(posedge clk);
		pe_load <= 1'b0;
		pe_end <= 1'b1;
		pe_ok <= ok;
		@(posedge clk);
		pe_end <= 1'b0;
		pe_frame <= ~f;
		@(posedge clk);
	endtask
	task automatic drive(input logic lvl, input int n);
		bus_receive_input <= lvl;
		repeat (n) @(posedge clk);
	endtask
endmodule // crb_can_node

/* File: tb/crb_rx_buf_checker.sv */
// crb_rx_buf_checker: port checks of the receive buffering block
// assumes zero wait apb and the register map of crb_pkg
`timescale 1ns/1ps
module crb_rx_buf_checker #(
	parameter int unsigned SAMPLE_CYC = crb_pkg::CRB_SAMPLE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input crb_pkg::crb_apb_req_t apb_req,
	input wire logic pe_end,
	input wire logic bus_receive_input,
	input wire logic sof_out,
	input wire logic irq_n,
	input wire logic slot0_full_out,
	input wire logic slot0_full_oe,
	input wire logic slot1_full_out,
	input wire logic slot1_full_oe
);
	import crb_pkg::*;
	logic [5:0] cfg_r;
	logic [1:0] ie_r;
	logic sof_en_r;
	logic [7:0] low_r;
	logic wr;
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_r <= 6'h00;
			ie_r <= 2'h0;
			sof_en_r <= 1'b0;
			low_r <= 8'h00;
		end else begin
			if (wr && apb_req.paddr == CRB_OFS_PINCFG) cfg_r <= apb_req.pwdata[5:0];
			if (wr && apb_req.paddr == CRB_OFS_IE) ie_r <= apb_req.pwdata[1:0];
			if (wr && apb_req.paddr == CRB_OFS_SOFCTL) sof_en_r <= apb_req.pwdata[0];
			low_r <= bus_receive_input ? 8'h00 : low_r + {7'h00, low_r != 8'hFF};
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_clr0;
		wr && apb_req.paddr == CRB_OFS_FULL && apb_req.pwdata[0] && !pe_end && cfg_r[2] && cfg_r[0];
	endsequence
	property p_oe; slot0_full_oe == cfg_r[2] && slot1_full_oe == cfg_r[3]; endproperty
	a_oe: assert property (p_oe) else $error("pin enable mismatch");
	property p_lvl; cfg_r[3] && !cfg_r[1] |-> slot1_full_out == cfg_r[5]; endproperty
	a_lvl: assert property (p_lvl) else $error("pin level mismatch");
	property p_lvl0; cfg_r[2] && !cfg_r[0] |-> slot0_full_out == cfg_r[4]; endproperty
	a_lvl0: assert property (p_lvl0) else $error("slot0 pin level mismatch");
	property p_pin_load;
		cfg_r[2] && cfg_r[0] && $stable(cfg_r) && $fell(slot0_full_out) |-> $past(pe_end);
	endproperty
	a_pin_load: assert property (p_pin_load) else $error("pin low without load");
	property p_pin_rel; s_clr0 |=> slot0_full_out; endproperty
	a_pin_rel: assert property (p_pin_rel) else $error("pin not released");
	property p_irq; $fell(irq_n) && $stable(ie_r) |-> $past(pe_end); endproperty
	a_irq: assert property (p_irq) else $error("irq without load");
	property p_sof_w; sof_out |=> !sof_out; endproperty
	a_sof_w: assert property (p_sof_w) else $error("sof pulse too long");
	property p_sof_low; sof_out |-> low_r >= SAMPLE_CYC; endproperty
	a_sof_low: assert property (p_sof_low) else $error("sof on short dominant");
	property p_sof_off; !sof_en_r && !$past(sof_en_r) |-> !sof_out; endproperty
	a_sof_off: assert property (p_sof_off) else $error("sof while disabled");
endmodule // crb_rx_buf_checker

bind crb_rx_buf crb_rx_buf_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (.clk, .sys_rst, .apb_req,
	.pe_end, .bus_receive_input, .sof_out, .irq_n, .slot0_full_out, .slot0_full_oe,
	.slot1_full_out, .slot1_full_oe);

/* File: tb/crb_rx_buf_tb.sv */
// crb_rx_buf_tb: self-checking bench of the receive buffering block
// assumes crb_can_node on the frame side and an apb master here
`timescale 1ns/1ps
module crb_rx_buf_tb;
	import crb_pkg::*;
	localparam logic [28:0] ID_S = 29'h0A340000;
	localparam logic [28:0] ID_E = 29'h12345678;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	crb_apb_req_t apb_req = '0;
	crb_apb_rsp_t apb_rsp;
	logic [28:0] mask0 = '1;
	logic [28:0] mask1 = '1;
	crb_filt_t [5:0] filters = '0;
	crb_frame_t pe_frame;
	logic pe_load, pe_end, pe_ok, bus_receive_input, sof_out, irq_n, err;
	logic slot0_full_out, slot0_full_oe, slot1_full_out, slot1_full_oe;
	logic [31:0] rd;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_sof = 0;
	crb_rx_buf dut (.clk, .sys_rst, .apb_req, .apb_rsp, .pe_load, .pe_frame, .pe_end, .pe_ok,
		.mask0, .mask1, .filters, .bus_receive_input, .sof_out, .irq_n, .slot0_full_out,
		.slot0_full_oe, .slot1_full_out, .slot1_full_oe);
	crb_can_node node (.clk, .pe_frame, .pe_load, .pe_end, .pe_ok, .bus_receive_input);
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) n_sof <= n_sof + int'(sof_out === 1'b1);
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		@(posedge clk);
		while (apb_rsp.pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge clk);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	function automatic crb_frame_t fr(input logic e, input logic r, input logic [28:0] id);
		return '{e, r, id, 4'h8, {3'h0, id, 3'h0, id}};
	endfunction
	task automatic slot(input logic [7:0] b, input crb_frame_t f);
		rdchk("slot id", b, {f.ide, f.rtr, 1'b0, f.id});
		rdchk("slot data", b + 8'h08, f.data[31:0]);
	endtask
	task automatic t_rst;
		for (int a = 0; a < 28; a += 4) begin
			rdchk("reset reg", 8'(a), 32'h0);
		end
		chk("reset pins", 32'h1, 32'({slot1_full_oe, slot0_full_oe, irq_n}));
		rdchk("unmapped", 8'h1C, 32'h0);
		chk("slverr", 32'h1, 32'(err));
	endtask
	task automatic t_acc;
		filters[0] <= '{1'b0, ID_S};
		filters[1] <= '{1'b1, ID_E};
		filters[2] <= '{1'b0, ID_S};
		apb(1'b1, CRB_OFS_IE, 32'h3);
		apb(1'b1, CRB_OFS_PINCFG, 32'hF);
		node.send(fr(1'b1, 1'b1, ID_E), 1'b1);
		rdchk("ctrl0", CRB_OFS_CTRL0, 32'h9);
		chk("irq pin", 32'h0, 32'({irq_n, slot0_full_out}));
		slot(CRB_OFS_SLOT0, fr(1'b1, 1'b1, ID_E));
		node.send(fr(1'b0, 1'b0, ID_S), 1'b1);
		rdchk("ovf", CRB_OFS_OVF, 32'h1);
		rdchk("full", CRB_OFS_FULL, 32'h1);
		slot(CRB_OFS_SLOT0, fr(1'b1, 1'b1, ID_E));
		apb(1'b1, CRB_OFS_FULL, 32'h1);
		apb(1'b1, CRB_OFS_OVF, 32'h1);
		chk("irq pin", 32'h3, 32'({irq_n, slot0_full_out}));
	endtask
	task automatic t_roll;
		filters[2] <= '0;
		apb(1'b1, CRB_OFS_CTRL0, 32'h4);
		node.send(fr(1'b0, 1'b0, ID_S), 1'b1);
		node.send(fr(1'b1, 1'b0, ID_E), 1'b1);
		rdchk("full", CRB_OFS_FULL, 32'h3);
		rdchk("ovf", CRB_OFS_OVF, 32'h0);
		rdchk("ctrl1", CRB_OFS_CTRL1, 32'h1);
		slot(CRB_OFS_SLOT1, fr(1'b1, 1'b0, ID_E));
		apb(1'b1, CRB_OFS_FULL, 32'h3);
		apb(1'b1, CRB_OFS_CTRL0, 32'h0);
		mask1 <= 29'h000000FF;
		filters[5] <= '{1'b1, 29'h55};
		node.send(fr(1'b1, 1'b1, 29'h1ABCDE55), 1'b1);
		rdchk("ctrl1", CRB_OFS_CTRL1, 32'hD);
		apb(1'b1, CRB_OFS_FULL, 32'h2);
		mask1 <= '1;
	endtask
	task automatic t_mode;
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, CRB_OFS_CTRL0, 32'(m << 5));
			for (int e = 0; e < 2; e++) begin
				node.send(fr(e[0], 1'b0, ID_S), 1'b1);
				rdchk("mode", CRB_OFS_FULL, 32'(m == 3 || (e == 0 && m != 2)));
				apb(1'b1, CRB_OFS_FULL, 32'h1);
			end
		end
		node.send(fr(1'b1, 1'b0, 29'h7), 1'b0);
		rdchk("partial", CRB_OFS_FULL, 32'h1);
		slot(CRB_OFS_SLOT0, fr(1'b1, 1'b0, 29'h7));
		apb(1'b1, CRB_OFS_FULL, 32'h1);
		apb(1'b1, CRB_OFS_CTRL0, 32'h0);
		node.send(fr(1'b0, 1'b0, ID_S), 1'b0);
		rdchk("dropped", CRB_OFS_FULL, 32'h0);
		// slot one in accept-all mode takes a frame that misses slot zero
		apb(1'b1, CRB_OFS_CTRL1, 32'h60);
		node.send(fr(1'b1, 1'b0, 29'h7), 1'b1);
		rdchk("ctrl1 all", CRB_OFS_CTRL1, 32'h62);
		rdchk("full all", CRB_OFS_FULL, 32'h2);
		apb(1'b1, CRB_OFS_FULL, 32'h2);
		apb(1'b1, CRB_OFS_CTRL1, 32'h0);
	endtask
	task automatic t_pin;
		apb(1'b1, CRB_OFS_PINCFG, 32'h1C);
		chk("pins", 32'hB, 32'({slot1_full_oe, slot1_full_out, slot0_full_oe, slot0_full_out}));
		apb(1'b1, CRB_OFS_PINCFG, 32'h24);
		chk("pins", 32'h2, 32'({slot1_full_oe, slot0_full_oe, slot0_full_out}));
	endtask
	task automatic t_sof;
		apb(1'b1, CRB_OFS_SOFCTL, 32'h1);
		node.drive(1'b1, 130);
		node.drive(1'b0, 3);
		node.drive(1'b1, 130);
		chk("glitch sof", 32'h0, 32'(n_sof));
		node.drive(1'b0, 20);
		node.drive(1'b1, 130);
		chk("sof", 32'h1, 32'(n_sof));
		apb(1'b1, CRB_OFS_SOFCTL, 32'h0);
		node.drive(1'b0, 20);
		node.drive(1'b1, 20);
		chk("sof off", 32'h1, 32'(n_sof));
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_rst;
		t_acc;
		t_roll;
		t_mode;
		t_pin;
		t_sof;
		complete_run;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		complete_run;
	end
endmodule // crb_rx_buf_tb

/* File: verilog/crb_rx_buf.sv */
// crb_rx_buf: receive buffering, acceptance, full flags and slot-full pins
// assumes a protocol engine feeding frames and an apb master for registers
// Functional notes
// [RULE1] assembly store captures every frame; hands it on only when filters accept
// [RULE2] acceptance copies the whole assembly store into the chosen slot
// [RULE3] loading a slot sets its full flag
// [RULE4] full slot is never reloaded; host clears flag to release it
// [RULE5] full flag with its irq enable drives the interrupt output
// [RULE6] slot zero has mask and two filters, checked first
// [RULE7] slot one has mask and four filters, checked after slot zero
// [RULE8] control low bits record matching filter and remote request
// [RULE9] rollover sends frame to slot one when slot zero full, no overflow
// [RULE10] mode 00 accepts filtered frames; filter ext bit picks identifier type
// [RULE11] mode 01 standard only, 10 extended only; mismatched filters never hit
// [RULE12] mode 11 accepts every frame ignoring masks and filters
// [RULE13] mode 11 loads partially assembled frame on error
// [RULE14] when enabled a pulse marks each start of frame
// [RULE15] idle bus falling edge held to sample point is start of frame
// [RULE16] dominant not held to sample point is a glitch, no pulse
// [RULE17] pin enable clear puts slot-full pin in high impedance
// [RULE18] enable and irq mode: pin active low following full flag
// [RULE19] clearing full flag returns pin high until next load
// [RULE20] enable without irq mode: pin drives its level bit
// [RULE21] accepted frame for full slot without rollover sets overflow flag
// [RULE22] accept mode sits in control bits six to five
// [RULE23] slot one index 000 to 101; 000 and 001 only after rollover
// [RULE24] slot zero match with slot zero full and no rollover is discarded
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module crb_rx_buf #(
	parameter int unsigned BIT_CYC = crb_pkg::CRB_BIT_CYC,
	parameter int unsigned SAMPLE_CYC = crb_pkg::CRB_SAMPLE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input crb_pkg::crb_apb_req_t apb_req,
	output crb_pkg::crb_apb_rsp_t apb_rsp,
	input wire logic pe_load,
	input crb_pkg::crb_frame_t pe_frame,
	input wire logic pe_end,
	input wire logic pe_ok,
	input wire logic [28:0] mask0,
	input wire logic [28:0] mask1,
	input crb_pkg::crb_filt_t [5:0] filters,
	input wire logic bus_receive_input,
	output logic sof_out,
	output logic irq_n,
	output logic slot0_full_out,
	output logic slot0_full_oe,
	output logic slot1_full_out,
	output logic slot1_full_oe
);
	import crb_pkg::*;

	typedef struct packed {
		crb_frame_t asm_st;
		crb_frame_t [1:0] slot;
		logic [1:0] mode0;
		logic [1:0] mode1;
		logic roll;
		logic hit0;
		logic [2:0] hit1;
		logic [1:0] full;
		logic [1:0] ie;
		logic [1:0] ovf;
		logic [5:0] pincfg;
		logic sof_en;
		logic [31:0] rdata;
		logic slverr;
	} crb_state_t;

	crb_state_t s_r;
	crb_state_t s_nxt;
	logic [5:0] hit;
	logic valid_end;
	logic err_end;
	logic m0;
	logic m1;
	logic idx0;
	logic [2:0] idx1;
	logic setup;
	logic wr_en;
	logic [31:0] rd_val;
	logic rd_bad;

	function automatic logic fmatch(
		input crb_frame_t f,
		input crb_filt_t flt,
		input logic [28:0] msk,
		input logic [1:0] md
	);
		logic [28:0] cm;
		logic ok;
		cm = f.ide ? msk : (msk & CRB_STD_ID_MASK);
		ok = (((f.id ^ flt.id) & cm) == 29'h00000000) && (flt.ext == f.ide);
		unique case (md)
			CRB_MODE_ANY: fmatch = ok; // [RULE10]
			CRB_MODE_STD: fmatch = ok && !f.ide; // [RULE11]
			CRB_MODE_EXT: fmatch = ok && f.ide; // [RULE11]
			CRB_MODE_ALL: fmatch = 1'b1; // [RULE12]
		endcase
	endfunction

	// per-filter comparison against the assembly store
	for (genvar i = 0; i < 6; i++) begin : g_filt
		if (i < 2) begin : g_s0
			assign hit[i] = fmatch(s_r.asm_st, filters[i], mask0, s_r.mode0); // [RULE6]
		end else begin : g_s1
			assign hit[i] = fmatch(s_r.asm_st, filters[i], mask1, s_r.mode1); // [RULE7]
		end
	end

	assign valid_end = pe_end && pe_ok;
	assign err_end = pe_end && !pe_ok;

	always_comb begin
		// slot zero offered first, slot one only if slot zero filters miss
		m0 = (valid_end && (hit[1:0] != 2'h0))
			|| (err_end && (s_r.mode0 == CRB_MODE_ALL)); // [RULE6] [RULE13]
		m1 = (valid_end && (hit[5:2] != 4'h0))
			|| (err_end && (s_r.mode1 == CRB_MODE_ALL)); // [RULE7] [RULE13]
		idx0 = !hit[0];
		if (hit[2]) begin
			idx1 = 3'h2;
		end else if (hit[3]) begin
			idx1 = 3'h3;
		end else if (hit[4]) begin
			idx1 = 3'h4;
		end else begin
			idx1 = 3'h5;
		end
	end

	assign setup = apb_req.psel && !apb_req.penable;
	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;

	always_comb begin
		logic [7:0] a;
		logic sl;
		logic [1:0] w;
		a = apb_req.paddr;
		sl = 1'b0;
		w = a[3:2];
		rd_val = 32'h00000000;
		rd_bad = 1'b0;
		if (a[1:0] != 2'h0) begin
			rd_bad = 1'b1;
		end else if (a == CRB_OFS_CTRL0) begin
			rd_val[CRB_CTL_MODE_LSB +: 2] = s_r.mode0; // [RULE22]
			rd_val[CRB_CTL_RTR_BIT] = s_r.slot[0].rtr;
			rd_val[CRB_CTL_ROLL_BIT] = s_r.roll;
			rd_val[CRB_CTL_ROLLCPY_BIT] = s_r.roll;
			rd_val[0] = s_r.hit0;
		end else if (a == CRB_OFS_CTRL1) begin
			rd_val[CRB_CTL_MODE_LSB +: 2] = s_r.mode1; // [RULE22]
			rd_val[CRB_CTL_RTR_BIT] = s_r.slot[1].rtr;
			rd_val[2:0] = s_r.hit1;
		end else if (a == CRB_OFS_FULL) begin
			rd_val[1:0] = s_r.full;
		end else if (a == CRB_OFS_IE) begin
			rd_val[1:0] = s_r.ie;
		end else if (a == CRB_OFS_OVF) begin
			rd_val[1:0] = s_r.ovf;
		end else if (a == CRB_OFS_PINCFG) begin
			rd_val[5:0] = s_r.pincfg;
			// level bits read zero in irq mode
			rd_val[CRB_PIN_LVL_LSB +: 2] = s_r.pincfg[CRB_PIN_LVL_LSB +: 2]
				& ~s_r.pincfg[CRB_PIN_MODE_LSB +: 2];
		end else if (a == CRB_OFS_SOFCTL) begin
			rd_val[0] = s_r.sof_en;
		end else if ((a[7:4] == CRB_OFS_SLOT0[7:4]) || (a[7:4] == CRB_OFS_SLOT1[7:4])) begin
			sl = (a[7:4] == CRB_OFS_SLOT1[7:4]);
			unique case (w)
				CRB_SW_ID: rd_val = {s_r.slot[sl].ide, s_r.slot[sl].rtr, 1'b0, s_r.slot[sl].id};
				CRB_SW_DLC: rd_val[3:0] = s_r.slot[sl].dlc;
				CRB_SW_DLO: rd_val = s_r.slot[sl].data[31:0];
				CRB_SW_DHI: rd_val = s_r.slot[sl].data[63:32];
			endcase
		end else begin
			rd_bad = 1'b1;
		end
	end

	always_comb begin
		logic [1:0] set_full;
		logic [1:0] set_ovf;
		logic [1:0] clr_full;
		logic [1:0] clr_ovf;
		logic [31:0] d;
		s_nxt = s_r;
		set_full = 2'h0;
		set_ovf = 2'h0;
		clr_full = 2'h0;
		clr_ovf = 2'h0;
		d = apb_req.pwdata;
		if (pe_load) begin
			s_nxt.asm_st = pe_frame; // [RULE1]
		end
		if (m0) begin
			if (!s_r.full[0]) begin // [RULE4]
				s_nxt.slot[0] = s_r.asm_st; // [RULE2]
				s_nxt.hit0 = idx0; // [RULE8]
				set_full[0] = 1'b1; // [RULE3]
			end else if (s_r.roll) begin
				if (!s_r.full[1]) begin
					s_nxt.slot[1] = s_r.asm_st; // [RULE9]
					s_nxt.hit1 = {2'h0, idx0}; // [RULE23]
					set_full[1] = 1'b1; // [RULE3]
				end else begin
					set_ovf[1] = 1'b1; // [RULE21]
				end
			end else begin
				set_ovf[0] = 1'b1; // [RULE21] [RULE24]
			end
		end else if (m1) begin
			if (!s_r.full[1]) begin // [RULE4]
				s_nxt.slot[1] = s_r.asm_st; // [RULE2]
				s_nxt.hit1 = idx1; // [RULE8] [RULE23]
				set_full[1] = 1'b1; // [RULE3]
			end else begin
				set_ovf[1] = 1'b1; // [RULE21]
			end
		end
		if (wr_en) begin
			unique case (apb_req.paddr)
				CRB_OFS_CTRL0: begin
					s_nxt.mode0 = d[CRB_CTL_MODE_LSB +: 2]; // [RULE22]
					s_nxt.roll = d[CRB_CTL_ROLL_BIT];
				end
				CRB_OFS_CTRL1: s_nxt.mode1 = d[CRB_CTL_MODE_LSB +: 2]; // [RULE22]
				CRB_OFS_FULL: clr_full = d[1:0];
				CRB_OFS_IE: s_nxt.ie = d[1:0];
				CRB_OFS_OVF: clr_ovf = d[1:0];
				CRB_OFS_PINCFG: s_nxt.pincfg = d[5:0];
				CRB_OFS_SOFCTL: s_nxt.sof_en = d[0];
				default: ;
			endcase
		end
		// hardware set wins over a write-one-to-clear in the same cycle
		s_nxt.full = (s_r.full & ~clr_full) | set_full; // [RULE4]
		s_nxt.ovf = (s_r.ovf & ~clr_ovf) | set_ovf;
		if (setup) begin
			s_nxt.rdata = apb_req.pwrite ? 32'h00000000 : rd_val;
			s_nxt.slverr = rd_bad;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.mode0 <= CRB_RST_MODE;
			s_r.mode1 <= CRB_RST_MODE;
			s_r.pincfg <= CRB_RST_PINCFG;
			s_r.sof_en <= CRB_RST_SOF_EN;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = s_r.slverr && apb_req.psel && apb_req.penable;
	assign apb_rsp.prdata = s_r.rdata;

	assign irq_n = ((s_r.full & s_r.ie) == 2'h0); // [RULE5]

	// slot-full pins: enable gates the driver, mode picks flag or level
	assign slot0_full_oe = s_r.pincfg[CRB_PIN_EN_LSB]; // [RULE17]
	assign slot1_full_oe = s_r.pincfg[CRB_PIN_EN_LSB + 1]; // [RULE17]
	assign slot0_full_out = s_r.pincfg[CRB_PIN_MODE_LSB]
		? !s_r.full[0] // [RULE18] [RULE19]
		: s_r.pincfg[CRB_PIN_LVL_LSB]; // [RULE20]
	assign slot1_full_out = s_r.pincfg[CRB_PIN_MODE_LSB + 1]
		? !s_r.full[1] // [RULE18] [RULE19]
		: s_r.pincfg[CRB_PIN_LVL_LSB + 1]; // [RULE20]

	crb_sof_det #(
		.BIT_CYC(BIT_CYC),
		.SAMPLE_CYC(SAMPLE_CYC),
		.IDLE_BITS(CRB_IDLE_BITS)
	) u_sof (
		.clk(clk),
		.sys_rst(sys_rst),
		.bus_receive_input(bus_receive_input),
		.sof_en(s_r.sof_en),
		.sof_out(sof_out) // [RULE14]
	);
endmodule // crb_rx_buf

/* File: verilog/crb_sof_det.sv */
// crb_sof_det: start-of-frame detector with glitch rejection on the bus line
// assumes bus_receive_input is asynchronous; 1 is recessive
`timescale 1ns/1ps
module crb_sof_det #(
	parameter int unsigned BIT_CYC = crb_pkg::CRB_BIT_CYC,
	parameter int unsigned SAMPLE_CYC = crb_pkg::CRB_SAMPLE_CYC,
	parameter int unsigned IDLE_BITS = crb_pkg::CRB_IDLE_BITS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic bus_receive_input,
	input wire logic sof_en,
	output logic sof_out
);
	import crb_pkg::*;

	typedef enum logic [1:0] {ST_BUSY, ST_IDLE, ST_CHECK} crb_sof_st_t;
	typedef struct packed {
		logic [2:0] sync;
		logic lvl;
		crb_sof_st_t st;
		logic [15:0] cnt;
		logic pulse;
	} crb_sof_state_t;

	localparam logic [15:0] IDLE_CYC = 16'(BIT_CYC * IDLE_BITS);
	localparam logic [15:0] SMP_CYC = 16'(SAMPLE_CYC);

	crb_sof_state_t s_r;
	crb_sof_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.pulse = 1'b0;
		s_nxt.sync = {s_r.sync[1:0], bus_receive_input};
		if (s_r.sync[2] == s_r.sync[1]) begin
			s_nxt.lvl = s_r.sync[2];
		end
		unique case (s_r.st)
			ST_BUSY: begin
				// wait for a recessive idle stretch
				if (!s_r.lvl) begin
					s_nxt.cnt = '0;
				end else if (s_r.cnt >= IDLE_CYC - 16'h0001) begin
					s_nxt.st = ST_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h0001;
				end
			end
			ST_IDLE: begin
				s_nxt.cnt = '0;
				if (!s_r.lvl) begin // [RULE15]
					s_nxt.st = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (s_r.lvl) begin
					s_nxt.st = ST_IDLE; // [RULE16]
				end else if (s_r.cnt >= SMP_CYC - 16'h0001) begin
					s_nxt.pulse = sof_en; // [RULE14]
					s_nxt.st = ST_BUSY;
					s_nxt.cnt = '0;
				end else begin
					s_nxt.cnt = s_r.cnt + 16'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '{sync: 3'h7, lvl: 1'b1, st: ST_BUSY, cnt: 16'h0000, pulse: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sof_out = s_r.pulse;
endmodule // crb_sof_det
